// File: pkg/csfr_pkg.sv
// Shared constants and types for the core special function registers
package csfr_pkg;

  localparam int unsigned PADDR_W = 9;
  localparam int unsigned PAGE_W = 6;
  localparam int unsigned PM_ADDR_W = 14;
  localparam int unsigned BANK_ADDR_W = 13;

  // Register indices; byte address is four times the index
  localparam logic [6:0] IDX_ACC = 7'h05;
  localparam logic [6:0] IDX_PC_LO = 7'h06;
  localparam logic [6:0] IDX_TPTR_LO = 7'h07;
  localparam logic [6:0] IDX_TLATCH = 7'h08;
  localparam logic [6:0] IDX_TPTR_HI = 7'h09;
  localparam logic [6:0] IDX_STATUS = 7'h0A;
  localparam logic [6:0] IDX_BANK_PTR = 7'h0B;
  localparam logic [6:0] IDX_UNLOCK = 7'h7F;

  // Status bit positions
  localparam int unsigned ST_C = 0;
  localparam int unsigned ST_HC = 1;
  localparam int unsigned ST_Z = 2;
  localparam int unsigned ST_WRAP = 3;
  localparam int unsigned ST_PWRDN = 4;
  localparam int unsigned ST_WDOG = 5;
  localparam int unsigned ST_CHAIN = 6;
  localparam int unsigned ST_SCMP = 7;

  localparam logic [7:0] BANK_PTR_RST = 8'h00;
  localparam logic [7:0] UNLOCK_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] TBL_RST = 8'h00;

  localparam logic [7:0] UNLOCK_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
  localparam logic [2:0] MAP_OSC_PERIODS = 3'h4;

  localparam logic [PAGE_W-1:0] LAST_PAGE = 6'h3F;
  localparam logic [1:0] OPT_WINDOW = 2'h3;
  localparam logic [7:0] ZERO8 = 8'h00;

  typedef enum logic [3:0] {
    CSFR_ADD = 4'h0,
    CSFR_ADC = 4'h1,
    CSFR_SUB = 4'h2,
    CSFR_SBC = 4'h3,
    CSFR_AND = 4'h4,
    CSFR_OR = 4'h5,
    CSFR_XOR = 4'h6,
    CSFR_RLC = 4'h7,
    CSFR_RRC = 4'h8
  } csfr_alu_kind_t;

  typedef struct packed {
    logic valid;
    csfr_alu_kind_t kind;
    logic [7:0] a;
    logic [7:0] b;
  } csfr_alu_op_t;

  typedef struct packed {
    logic [7:0] res;
    logic c;
    logic hc;
    logic wrap;
    logic z;
  } csfr_alu_res_t;

  typedef struct packed {
    logic req;
    logic opt_sel;
    logic [PM_ADDR_W-1:0] addr;
  } csfr_pm_req_t;

  typedef enum logic [1:0] {
    CSFR_UL_IDLE = 2'h1,
    CSFR_UL_ARMED = 2'h2
  } csfr_unlock_t;

endpackage

// File: hw/csfr_map_timer.sv
// Option-map window timer counting low-speed oscillator periods
`timescale 1ns/1ns
`default_nettype none
module csfr_map_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow_osc_in,
  input wire logic start,
  output logic map_en
);

  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  logic osc_rise;
  logic [2:0] cnt_r;
  logic active_r;

  // Two-stage synchroniser, then edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 1'h0;
      sync2_r <= 1'h0;
      sync3_r <= 1'h0;
    end else begin
      sync1_r <= slow_osc_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  assign osc_rise = sync2_r & ~sync3_r;

  // Restart on every unlock, expire after four periods
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 3'h0;
      active_r <= 1'h0;
    end else if (start) begin
      cnt_r <= csfr_pkg::MAP_OSC_PERIODS;
      active_r <= 1'h1;
    end else if (active_r && osc_rise) begin
      cnt_r <= cnt_r - 3'h1;
      if (cnt_r == 3'h1) begin
        active_r <= 1'h0;
      end
    end
  end

  assign map_en = active_r;

  a_map_restart: assert property (@(posedge pclk) disable iff (!presetn)
    start |=> map_en && cnt_r == 3'h4)
    else $error("unlock did not restart the map timer");

  a_map_expire: assert property (@(posedge pclk) disable iff (!presetn)
    (map_en && osc_rise && !start && cnt_r == 3'h1) |=> !map_en)
    else $error("map window did not end after four periods");

endmodule
`default_nettype wire

// File: hw/csfr_core_regs.sv
// Core special function registers behind an APB slave
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module csfr_core_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [csfr_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire csfr_pkg::csfr_alu_op_t alu,
  input wire logic branch_req,
  input wire logic [csfr_pkg::BANK_ADDR_W-1:0] branch_target,
  output logic branch_valid,
  output logic [csfr_pkg::PM_ADDR_W-1:0] branch_addr,
  input wire logic [7:0] pc_low,
  input wire logic [csfr_pkg::PAGE_W-1:0] pc_page,
  output logic jump_valid,
  output logic [csfr_pkg::PM_ADDR_W-1:0] jump_addr,
  output logic dummy_cycle,
  input wire logic tbl_rd,
  input wire logic tbl_last,
  output csfr_pkg::csfr_pm_req_t pm,
  input wire logic pm_ack,
  input wire logic [15:0] pm_rdata,
  output logic tbl_low_valid,
  output logic [7:0] tbl_low_data,
  input wire logic slow_osc,
  input wire logic wake,
  input wire logic wdt_timeout,
  input wire logic watchdog_clear_instruction,
  input wire logic halt,
  output logic map_enabled
);

  logic [7:0] bank_ptr_r;
  logic [7:0] unlock_reg_r;
  logic [7:0] status_r;
  logic [7:0] flags_r;
  logic pwrdn_r;
  logic wdog_r;
  logic [7:0] acc_r;
  logic [7:0] tptr_lo_r;
  logic [7:0] tptr_hi_r;
  logic [7:0] tlatch_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic branch_valid_r;
  logic [csfr_pkg::PM_ADDR_W-1:0] branch_addr_r;
  logic jump_valid_r;
  logic [csfr_pkg::PM_ADDR_W-1:0] jump_addr_r;
  logic dummy_r;
  csfr_pkg::csfr_pm_req_t pm_r;
  logic busy_r;
  logic tbl_low_valid_r;
  logic [7:0] tbl_low_data_r;
  csfr_pkg::csfr_unlock_t ul_r;
  logic unlock_pulse_r;
  logic [6:0] idx;
  logic setup;
  logic wr_ok;
  logic hit;
  logic [7:0] rd_val;
  logic [7:0] wbyte;
  csfr_pkg::csfr_alu_res_t ar;
  logic [csfr_pkg::PAGE_W-1:0] tbl_page;
  logic arith;

  function automatic logic known_idx(input logic [6:0] i);
    known_idx = (i == csfr_pkg::IDX_ACC) || (i == csfr_pkg::IDX_PC_LO) ||
      (i == csfr_pkg::IDX_TPTR_LO) || (i == csfr_pkg::IDX_TLATCH) ||
      (i == csfr_pkg::IDX_TPTR_HI) || (i == csfr_pkg::IDX_STATUS) ||
      (i == csfr_pkg::IDX_BANK_PTR) || (i == csfr_pkg::IDX_UNLOCK);
  endfunction

  // Adder-based ALU with flag extraction
  function automatic csfr_pkg::csfr_alu_res_t alu_calc(
    input csfr_pkg::csfr_alu_kind_t k,
    input logic [7:0] a,
    input logic [7:0] b,
    input logic cf
  );
    logic [7:0] bb;
    logic cin;
    logic [8:0] s9;
    logic [4:0] s5;
    logic [7:0] s7;
    csfr_pkg::csfr_alu_res_t r;
    bb = ((k == csfr_pkg::CSFR_SUB) || (k == csfr_pkg::CSFR_SBC)) ? ~b : b;
    cin = (k == csfr_pkg::CSFR_SUB) ? 1'h1 :
      ((k == csfr_pkg::CSFR_ADC) || (k == csfr_pkg::CSFR_SBC)) ? cf : 1'h0;
    s9 = {1'h0, a} + {1'h0, bb} + {8'h00, cin};
    s5 = {1'h0, a[3:0]} + {1'h0, bb[3:0]} + {4'h0, cin};
    s7 = {1'h0, a[6:0]} + {1'h0, bb[6:0]} + {7'h00, cin};
    r.res = s9[7:0];
    r.c = s9[8];
    r.hc = s5[4];
    r.wrap = s7[7] ^ s9[8];
    unique case (k)
      csfr_pkg::CSFR_AND: r.res = a & b;
      csfr_pkg::CSFR_OR: r.res = a | b;
      csfr_pkg::CSFR_XOR: r.res = a ^ b;
      csfr_pkg::CSFR_RLC: begin
        r.res = {a[6:0], cf};
        r.c = a[7];
      end
      csfr_pkg::CSFR_RRC: begin
        r.res = {cf, a[7:1]};
        r.c = a[0];
      end
      default: r.res = s9[7:0];
    endcase
    r.z = (r.res == csfr_pkg::ZERO8);
    alu_calc = r;
  endfunction

  // APB decode
  assign idx = paddr[csfr_pkg::PADDR_W-1:2];
  assign setup = psel & ~penable;
  assign hit = known_idx(idx) && (paddr[1:0] == 2'h0);
  assign wr_ok = psel & penable & pwrite & hit;
  assign wbyte = pwdata[7:0];
  assign pready = 1'h1;

  always_comb begin
    rd_val = csfr_pkg::ZERO8;
    unique case (idx)
      csfr_pkg::IDX_ACC: rd_val = acc_r;
      csfr_pkg::IDX_PC_LO: rd_val = pc_low;
      csfr_pkg::IDX_TPTR_LO: rd_val = tptr_lo_r;
      csfr_pkg::IDX_TLATCH: rd_val = tlatch_r;
      csfr_pkg::IDX_TPTR_HI: rd_val = tptr_hi_r;
      csfr_pkg::IDX_STATUS: rd_val = status_r;
      csfr_pkg::IDX_BANK_PTR: rd_val = {7'h00, bank_ptr_r[0]};
      csfr_pkg::IDX_UNLOCK: rd_val = unlock_reg_r;
      default: rd_val = csfr_pkg::ZERO8;
    endcase
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'h0;
    end else if (setup) begin
      prdata_r <= {24'h000000, (hit ? rd_val : csfr_pkg::ZERO8)};
      pslverr_r <= ~hit;
    end
  end

  assign prdata = prdata_r;
  assign pslverr = pslverr_r & psel & penable;

  // Bank pointer and branch target
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_ptr_r <= csfr_pkg::BANK_PTR_RST;
    end else if (wr_ok && idx == csfr_pkg::IDX_BANK_PTR) begin
      bank_ptr_r <= {7'h00, wbyte[0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      branch_valid_r <= 1'h0;
      branch_addr_r <= '0;
    end else begin
      branch_valid_r <= branch_req;
      if (branch_req) begin
        branch_addr_r <= {bank_ptr_r[0], branch_target};
      end
    end
  end

  assign branch_valid = branch_valid_r;
  assign branch_addr = branch_addr_r;

  // Program counter low write: in-page jump plus dummy cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jump_valid_r <= 1'h0;
      jump_addr_r <= '0;
      dummy_r <= 1'h0;
    end else begin
      jump_valid_r <= wr_ok && (idx == csfr_pkg::IDX_PC_LO);
      dummy_r <= jump_valid_r;
      if (wr_ok && idx == csfr_pkg::IDX_PC_LO) begin
        jump_addr_r <= {pc_page, wbyte};
      end
    end
  end

  assign jump_valid = jump_valid_r;
  assign jump_addr = jump_addr_r;
  assign dummy_cycle = dummy_r;

  // Accumulator takes software writes and every ALU result
  assign ar = alu_calc(alu.kind, alu.a, alu.b, status_r[csfr_pkg::ST_C]);
  assign arith = (alu.kind == csfr_pkg::CSFR_ADD) ||
    (alu.kind == csfr_pkg::CSFR_ADC) || (alu.kind == csfr_pkg::CSFR_SUB) ||
    (alu.kind == csfr_pkg::CSFR_SBC);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= csfr_pkg::ACC_RST;
    end else if (alu.valid) begin
      acc_r <= ar.res;
    end else if (wr_ok && idx == csfr_pkg::IDX_ACC) begin
      acc_r <= wbyte;
    end
  end

  // Arithmetic flags; ALU update outranks a same-cycle software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= csfr_pkg::STATUS_RST;
    end else if (alu.valid && arith) begin
      flags_r[csfr_pkg::ST_C] <= ar.c;
      flags_r[csfr_pkg::ST_HC] <= ar.hc;
      flags_r[csfr_pkg::ST_Z] <= ar.z;
      flags_r[csfr_pkg::ST_WRAP] <= ar.wrap;
      flags_r[csfr_pkg::ST_SCMP] <= ar.wrap ^ ar.res[7];
      if (alu.kind == csfr_pkg::CSFR_SUB) begin
        flags_r[csfr_pkg::ST_CHAIN] <= ar.z;
      end else if (alu.kind == csfr_pkg::CSFR_SBC) begin
        flags_r[csfr_pkg::ST_CHAIN] <= flags_r[csfr_pkg::ST_CHAIN] & ar.z;
      end
    end else if (alu.valid && (alu.kind == csfr_pkg::CSFR_RLC ||
        alu.kind == csfr_pkg::CSFR_RRC)) begin
      flags_r[csfr_pkg::ST_C] <= ar.c;
    end else if (alu.valid) begin
      flags_r[csfr_pkg::ST_Z] <= ar.z;
    end else if (wr_ok && idx == csfr_pkg::IDX_STATUS) begin
      flags_r[3:0] <= wbyte[3:0];
      flags_r[7:6] <= wbyte[7:6];
    end
  end

  // Power-down flag: set by halt wins over clear; not software writable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwrdn_r <= 1'h0;
    end else if (halt) begin
      pwrdn_r <= 1'h1;
    end else if (watchdog_clear_instruction) begin
      pwrdn_r <= 1'h0;
    end
  end

  // Watchdog flag: timeout wins over clear; no save path exists
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdog_r <= 1'h0;
    end else if (wdt_timeout) begin
      wdog_r <= 1'h1;
    end else if (watchdog_clear_instruction || halt) begin
      wdog_r <= 1'h0;
    end
  end

  assign status_r = {flags_r[7:6], wdog_r, pwrdn_r, flags_r[3:0]};

  // Table pointer pair
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tptr_lo_r <= csfr_pkg::TBL_RST;
      tptr_hi_r <= csfr_pkg::TBL_RST;
    end else if (wr_ok) begin
      if (idx == csfr_pkg::IDX_TPTR_LO) begin
        tptr_lo_r <= wbyte;
      end
      if (idx == csfr_pkg::IDX_TPTR_HI) begin
        tptr_hi_r <= wbyte;
      end
    end
  end

  // Table fetch with option window overlay on the last page
  assign tbl_page = tbl_last ? csfr_pkg::LAST_PAGE :
    tptr_hi_r[csfr_pkg::PAGE_W-1:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm_r <= '0;
      busy_r <= 1'h0;
    end else begin
      pm_r.req <= 1'h0;
      if (tbl_rd && !busy_r) begin
        busy_r <= 1'h1;
        pm_r.req <= 1'h1;
        if (map_enabled && tbl_page == csfr_pkg::LAST_PAGE &&
            tptr_lo_r[7:6] == csfr_pkg::OPT_WINDOW) begin
          pm_r.opt_sel <= 1'h1;
          pm_r.addr <= {8'h00, tptr_lo_r[5:0]};
        end else begin
          pm_r.opt_sel <= 1'h0;
          pm_r.addr <= {tbl_page, tptr_lo_r};
        end
      end else if (pm_ack) begin
        busy_r <= 1'h0;
      end
    end
  end

  assign pm = pm_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tlatch_r <= csfr_pkg::TBL_RST;
      tbl_low_valid_r <= 1'h0;
      tbl_low_data_r <= csfr_pkg::TBL_RST;
    end else begin
      tbl_low_valid_r <= pm_ack && busy_r;
      if (pm_ack && busy_r) begin
        tlatch_r <= pm_rdata[15:8];
        tbl_low_data_r <= pm_rdata[7:0];
      end else if (wr_ok && idx == csfr_pkg::IDX_TLATCH) begin
        tlatch_r <= wbyte;
      end
    end
  end

  assign tbl_low_valid = tbl_low_valid_r;
  assign tbl_low_data = tbl_low_data_r;

  // Unlock register; wake-up clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_reg_r <= csfr_pkg::UNLOCK_RST;
    end else if (wake) begin
      unlock_reg_r <= csfr_pkg::UNLOCK_RST;
    end else if (wr_ok && idx == csfr_pkg::IDX_UNLOCK) begin
      unlock_reg_r <= wbyte;
    end
  end

  // Unlock sequencer: second write must be the very next transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ul_r <= csfr_pkg::CSFR_UL_IDLE;
      unlock_pulse_r <= 1'h0;
    end else begin
      unlock_pulse_r <= 1'h0;
      unique case (ul_r)
        csfr_pkg::CSFR_UL_IDLE: begin
          if (wr_ok && idx == csfr_pkg::IDX_UNLOCK &&
              wbyte == csfr_pkg::UNLOCK_FIRST) begin
            ul_r <= csfr_pkg::CSFR_UL_ARMED;
          end
        end
        csfr_pkg::CSFR_UL_ARMED: begin
          if (!psel) begin
            ul_r <= csfr_pkg::CSFR_UL_IDLE;
          end else if (psel && penable) begin
            ul_r <= csfr_pkg::CSFR_UL_IDLE;
            if (wr_ok && idx == csfr_pkg::IDX_UNLOCK &&
                wbyte == csfr_pkg::UNLOCK_SECOND) begin
              unlock_pulse_r <= 1'h1;
            end else if (wr_ok && idx == csfr_pkg::IDX_UNLOCK &&
                wbyte == csfr_pkg::UNLOCK_FIRST) begin
              ul_r <= csfr_pkg::CSFR_UL_ARMED;
            end
          end
        end
      endcase
    end
  end

  csfr_map_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .slow_osc_in(slow_osc),
    .start(unlock_pulse_r),
    .map_en(map_enabled)
  );

  a_bank_select: assert property (@(posedge pclk) disable iff (!presetn)
    branch_req |=> branch_valid && branch_addr[13] == $past(bank_ptr_r[0]))
    else $error("branch bank not taken from bank pointer");

  a_bank_upper: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pwrite && paddr[8:2] == 7'h0B) |->
    prdata[7:1] == 7'h00)
    else $error("bank pointer upper bits not zero");

  a_pc_jump: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ok && idx == 7'h06) |=> jump_valid && !dummy_cycle ##1
    dummy_cycle && !jump_valid)
    else $error("program counter jump or dummy cycle wrong");

  a_tbl_high: assert property (@(posedge pclk) disable iff (!presetn)
    (pm_ack && busy_r) |=> tlatch_r == $past(pm_rdata[15:8]) &&
    tbl_low_valid)
    else $error("table high byte not latched");

  a_unlock_pair: assert property (@(posedge pclk) disable iff (!presetn)
    unlock_pulse_r |-> $past(unlock_reg_r, 2) == 8'h55 &&
    unlock_reg_r == 8'hAA)
    else $error("unlock fired without the pattern");

  a_unlock_gap: assert property (@(posedge pclk) disable iff (!presetn)
    (ul_r == csfr_pkg::CSFR_UL_ARMED && !psel) |=> !unlock_pulse_r ##1
    !unlock_pulse_r)
    else $error("unlock survived an idle gap");

  a_opt_window: assert property (@(posedge pclk) disable iff (!presetn)
    (tbl_rd && !busy_r && !map_enabled) |=> !pm.opt_sel)
    else $error("option memory selected while unmapped");

  a_wake_clear: assert property (@(posedge pclk) disable iff (!presetn)
    wake |=> unlock_reg_r == 8'h00)
    else $error("unlock register not cleared on wake");

  a_flag_ro: assert property (@(posedge pclk) disable iff (!presetn)
    (!halt && !watchdog_clear_instruction && !wdt_timeout) |=>
    $stable(status_r[5:4]))
    else $error("watchdog or power-down flag changed");

  a_scmp_xor: assert property (@(posedge pclk) disable iff (!presetn)
    (alu.valid && arith) |=> status_r[7] == (status_r[3] ^ acc_r[7]))
    else $error("signed compare flag wrong");

  a_chain_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (alu.valid && alu.kind == csfr_pkg::CSFR_SBC) |=>
    status_r[6] == ($past(status_r[6]) & status_r[2]))
    else $error("chained zero flag wrong");

  a_wdog_set: assert property (@(posedge pclk) disable iff (!presetn)
    wdt_timeout |=> status_r[5] ##1 (status_r[5] || $past(watchdog_clear_instruction) ||
    $past(halt)))
    else $error("watchdog flag not set by timeout");

endmodule
`default_nettype wire

// File: tb/csfr_core_regs_bench.sv
// Self-checking bench for the core special function register block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  bad_count++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module csfr_core_regs_bench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, tbl_last = 1'b0, slow_osc = 1'b0;
  logic [8:0] paddr = 9'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  csfr_pkg::csfr_alu_op_t alu = '0;
  logic [12:0] branch_target = 13'h0ABC;
  logic [5:0] pc_page = 6'h2A;
  logic [15:0] pm_rdata = 16'h0000;
  logic [6:0] ev = 7'h00;
  logic branch_valid, jump_valid, dummy_cycle, tbl_low_valid, map_enabled;
  logic se, jq = 1'b0, dq = 1'b0;
  logic [13:0] branch_addr, jump_addr, ja = 14'h0000;
  logic [7:0] tbl_low_data;
  csfr_pkg::csfr_pm_req_t pm;
  int bad_count = 0, checks_done = 0, cyc = 0;
  logic [35:0] tab [9];

  csfr_core_regs csfr_core_regs_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .alu, .branch_req(ev[4]),
    .branch_target, .branch_valid, .branch_addr, .pc_low(8'h00), .pc_page,
    .jump_valid, .jump_addr, .dummy_cycle, .tbl_rd(ev[5]), .tbl_last, .pm,
    .pm_ack(ev[6]), .pm_rdata, .tbl_low_valid, .tbl_low_data, .slow_osc,
    .wake(ev[3]), .wdt_timeout(ev[2]), .watchdog_clear_instruction(ev[1]), .halt(ev[0]),
    .map_enabled);

  always #10 pclk = ~pclk;

  // Jump pulse monitor and run limit
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    jq <= jump_valid;
    if (jump_valid === 1'b1) ja <= jump_addr;
    if (dummy_cycle === 1'b1) dq <= jq;
    if (cyc == 5000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One APB transfer; keep holds psel for a back-to-back setup
  task automatic xfer(input logic w, input logic [6:0] ix,
    input logic [7:0] d, input logic keep);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ix, 2'h0};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    penable <= 1'b0;
    if (!keep) begin
      psel <= 1'b0;
      @(posedge pclk);
    end
  endtask

  task automatic rdchk(input logic [6:0] ix, input logic [7:0] e,
    input string nm);
    xfer(1'b0, ix, 8'h00, 1'b0);
    `CHK(nm, {24'h000000, e}, rd)
  endtask

  task automatic pulse(input int b);
    ev[b] <= 1'b1;
    @(posedge pclk);
    ev <= 7'h00;
    #1;
  endtask

  task automatic unlock(input logic keep, input logic [7:0] d2);
    xfer(1'b1, csfr_pkg::IDX_UNLOCK, 8'h55, keep);
    xfer(1'b1, csfr_pkg::IDX_UNLOCK, d2, 1'b0);
    repeat (2) @(posedge pclk);
    #1;
  endtask

  task automatic lp(input int n);
    repeat (n) begin
      slow_osc <= 1'b1;
      repeat (4) @(posedge pclk);
      slow_osc <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    #1;
  endtask

  task automatic alu_run;
    foreach (tab[i]) begin
      alu <= '{1'b1, csfr_pkg::csfr_alu_kind_t'(tab[i][35:32]),
        tab[i][31:24], tab[i][23:16]};
      @(posedge pclk);
      alu.valid <= 1'b0;
      rdchk(csfr_pkg::IDX_ACC, tab[i][15:8], "acc");
      rdchk(csfr_pkg::IDX_STATUS, tab[i][7:0], "flags");
    end
  endtask

  initial begin
    // Kind, a, b, accumulator, flags
    tab = '{36'h07F01800A, 36'h1FF00FF80, 36'h205050047, 36'h310001003,
      36'h4F00F0007, 36'h500010103, 36'h65A5A0007, 36'h802008106,
      36'h780000007};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(csfr_pkg::IDX_STATUS, 8'h00, "status rst");
    rdchk(csfr_pkg::IDX_UNLOCK, 8'h00, "unlock rst");
    xfer(1'b0, 7'h00, 8'h00, 1'b0);
    `CHK("unmapped", 33'h100000000, {se, rd})
    $display("reset test done");
    xfer(1'b1, csfr_pkg::IDX_BANK_PTR, 8'hFF, 1'b0);
    rdchk(csfr_pkg::IDX_BANK_PTR, 8'h01, "bank reg");
    pulse(4);
    `CHK("bank1", 15'h6ABC, {branch_valid, branch_addr})
    xfer(1'b1, csfr_pkg::IDX_BANK_PTR, 8'h00, 1'b0);
    pulse(4);
    `CHK("bank0", 15'h4ABC, {branch_valid, branch_addr})
    xfer(1'b1, csfr_pkg::IDX_PC_LO, 8'h5C, 1'b0);
    repeat (2) @(posedge pclk);
    `CHK("jump", 15'h6A5C, {dq, ja})
    $display("branch test done");
    xfer(1'b1, csfr_pkg::IDX_STATUS, 8'hFF, 1'b0);
    rdchk(csfr_pkg::IDX_STATUS, 8'hCF, "st wr");
    pulse(0);
    rdchk(csfr_pkg::IDX_STATUS, 8'hDF, "st halt");
    pulse(2);
    rdchk(csfr_pkg::IDX_STATUS, 8'hFF, "st wdt");
    pulse(0);
    rdchk(csfr_pkg::IDX_STATUS, 8'hDF, "st halt2");
    xfer(1'b1, csfr_pkg::IDX_STATUS, 8'h00, 1'b0);
    rdchk(csfr_pkg::IDX_STATUS, 8'h10, "st wr0");
    pulse(1);
    rdchk(csfr_pkg::IDX_STATUS, 8'h00, "st clr");
    alu_run();
    $display("flag test done");
    unlock(1'b1, 8'hAA);
    `CHK("map on", 1'b1, map_enabled)
    xfer(1'b1, csfr_pkg::IDX_TPTR_LO, 8'hC5, 1'b0);
    xfer(1'b1, csfr_pkg::IDX_TPTR_HI, 8'h3F, 1'b0);
    pulse(5);
    `CHK("opt req", 8'hC5, {pm.req, pm.opt_sel, pm.addr[5:0]})
    pm_rdata <= 16'hBEEF;
    pulse(6);
    `CHK("tbl low", 9'h1EF, {tbl_low_valid, tbl_low_data})
    rdchk(csfr_pkg::IDX_TLATCH, 8'hBE, "tbl high");
    lp(2);
    unlock(1'b1, 8'hAA);
    lp(3);
    `CHK("map kept", 1'b1, map_enabled)
    lp(1);
    `CHK("map off", 1'b0, map_enabled)
    xfer(1'b1, csfr_pkg::IDX_TPTR_HI, 8'h12, 1'b0);
    tbl_last <= 1'b1;
    pulse(5);
    `CHK("pm req", 16'hBFC5, {pm.req, pm.opt_sel, pm.addr})
    pulse(6);
    unlock(1'b0, 8'hAA);
    `CHK("gap", 1'b0, map_enabled)
    unlock(1'b1, 8'h12);
    `CHK("bad 2nd", 1'b0, map_enabled)
    rdchk(csfr_pkg::IDX_UNLOCK, 8'h12, "unlock rw");
    pulse(3);
    rdchk(csfr_pkg::IDX_UNLOCK, 8'h00, "wake clr");
    $display("map test done");
    summarize();
  end
endmodule
`default_nettype wire
